// *** hdl/ufc_regs.svh ***
// register offsets, field positions, reset values and counts of the mode block
`ifndef UFC_REGS_SVH
`define UFC_REGS_SVH

// register offsets on the plain port
`define UFC_ADDR_MODE       4'h0
`define UFC_ADDR_CHAN_STAT  4'h1
`define UFC_ADDR_COMMAND    4'h2
`define UFC_ADDR_INT_STAT   4'h3
`define UFC_ADDR_EVT_STAT   4'h4
`define UFC_ADDR_EVT_CLEAR  4'h5
`define UFC_ADDR_EVT_ENABLE 4'h6

// mode register zero fields
`define UFC_M0_IDLE_EN      7
`define UFC_M0_RX_HI        6
`define UFC_M0_TX_HI        5
`define UFC_M0_TX_LO        4
`define UFC_M0_DEPTH        3
`define UFC_M0_RATE_HI      2
`define UFC_M0_RATE_LO      0
// mode register one fields
`define UFC_M1_FLOW_HOLD    7
`define UFC_M1_RX_LO        6
`define UFC_M1_ERR_STYLE    5

// command register fields
`define UFC_CMD_CODE_HI     7
`define UFC_CMD_CODE_LO     4
`define UFC_CMD_TX_OFF      3
`define UFC_CMD_TX_ON       2
`define UFC_CMD_RX_OFF      1
`define UFC_CMD_RX_ON       0
`define UFC_CMD_PTR_ZERO    4'hB
`define UFC_CMD_PTR_ONE     4'h1

// legal baud-rate group codes
`define UFC_RATE_NORMAL     3'h0
`define UFC_RATE_EXT_ONE    3'h1
`define UFC_RATE_EXT_TWO    3'h4

// reset values
`define UFC_MODE_RESET      8'h00
`define UFC_EVT_RESET       3'h0

// event bit positions
`define UFC_EVT_TX          0
`define UFC_EVT_RX          1
`define UFC_EVT_RATE        2

// queue depths and fill thresholds
`define UFC_DEPTH_SMALL     5'h08
`define UFC_DEPTH_LARGE     5'h10
`define UFC_RX8_T0          5'h01
`define UFC_RX8_T1          5'h03
`define UFC_RX8_T2          5'h06
`define UFC_RX8_T3          5'h08
`define UFC_RX16_T0         5'h01
`define UFC_RX16_T1         5'h08
`define UFC_RX16_T2         5'h0C
`define UFC_RX16_T3         5'h10
`define UFC_TX8_T0          5'h08
`define UFC_TX8_T1          5'h04
`define UFC_TX8_T2          5'h06
`define UFC_TX8_T3          5'h01
`define UFC_TX16_T0         5'h10
`define UFC_TX16_T1         5'h08
`define UFC_TX16_T2         5'h0C
`define UFC_TX16_T3         5'h01

// receiver idle watchdog length in bit times
`define UFC_IDLE_BITS       64

`endif

// *** hdl/ufc_pkg.sv ***
// types shared by the mode configuration block
package ufc_pkg;
   // which mode register the shared mode address reaches
   typedef enum logic [1:0] {
      UFC_PTR_MODE0,
      UFC_PTR_MODE1,
      UFC_PTR_MODE2
   } ufc_ptr_e;
   typedef logic [4:0] ufc_level_t;   // queue fill count 0..16
   typedef logic [1:0] ufc_code_t;    // two-bit threshold code
endpackage

// *** hdl/ufc_idle_watchdog.sv ***
// receiver idle watchdog counting 1x bit periods
`timescale 1ns/1ps
`include "ufc_regs.svh"
module ufc_idle_watchdog
   import ufc_pkg::*;
#(
   parameter int unsigned IDLE_BITS = `UFC_IDLE_BITS
) (
   input  wire logic core_clk_in,
   input  wire logic resetn_in,
   input  wire logic tick_in,      // one pulse per receiver bit time
   input  wire logic enable_in,    // watchdog enabled by software
   input  wire logic restart_in,   // any receive queue access
   output logic      alarm_out     // idle alarm, held until restart or disable
);
   localparam int unsigned CW = $clog2(IDLE_BITS + 1);
   localparam logic [CW-1:0] LAST = CW'(IDLE_BITS - 1);

   logic [CW-1:0] count;           // bit periods seen since last access
   wire           at_last = (count == LAST);

   // count while enabled, restart on access, hold zero when off
   always_ff @(posedge core_clk_in) begin
      if (!resetn_in) begin
         count     <= '0;
         alarm_out <= 1'b0;
      end else if (!enable_in || restart_in) begin
         count     <= '0;
         alarm_out <= 1'b0;
      end else if (tick_in && !alarm_out) begin
         // the alarm stays up until the queue is touched again or the watchdog is turned off
         count     <= at_last ? '0 : count + 1'b1;
         alarm_out <= at_last;
      end
   end

   a_wd_off_hold:
   assert property (@(posedge core_clk_in) disable iff (!resetn_in)
      !enable_in |=> (count == '0) && !alarm_out)
   else $error("watchdog not held at zero while disabled");

   a_wd_alarm_cause:
   assert property (@(posedge core_clk_in) disable iff (!resetn_in)
      $rose(alarm_out) |-> $past(tick_in) && $past(at_last))
   else $error("idle alarm raised without the last bit period");
endmodule

// *** hdl/ufc_mode_config.sv ***
// mode registers, fifo thresholds and idle watchdog of serial channel a
//
// Functional notes
// - idle alarm after 64 idle receiver bit times
// - idle alarm shows as receiver ready interrupt
// - rx code is mode0 bit6 over mode1 bit6
// - 8-deep rx thresholds 1,3,6,8 bytes
// - 16-deep rx thresholds 1,8,12,16 bytes
// - 8-deep tx vacancy thresholds 8,4,6,1
// - 16-deep tx vacancy thresholds 16,8,12,1
// - tx request drops once vacancy under threshold
// - empty tx queue requests once transmitter enabled
// - mode0 bit3 selects 8 or 16 depth
// - rate group codes 000, 001, 100 only; other codes still load and raise the rate event
// - new threshold code waits for empty or access, depth bit acts at once
// - command B points at mode register zero
// - reset or command 1 points mode one, advances
`timescale 1ns/1ps
`include "ufc_regs.svh"
module ufc_mode_config
   import ufc_pkg::*;
#(
   parameter int unsigned IDLE_BITS = `UFC_IDLE_BITS
) (
   input  wire logic       core_clk_in,
   input  wire logic       resetn_in,
   input  wire logic [3:0] addr_in,
   input  wire logic [7:0] wr_data_in,
   input  wire logic       wr_in,
   input  wire logic       rd_in,
   input  wire logic [4:0] rx_level_in,      // bytes held in receive queue
   input  wire logic [4:0] tx_level_in,      // bytes held in transmit queue
   input  wire logic       rx_queue_read_in, // receive queue pop
   input  wire logic       rx_queue_write_in,// receive queue push
   input  wire logic       tx_queue_read_in, // transmit queue pop
   input  wire logic       tx_queue_write_in,// transmit queue push
   input  wire logic       rx_bit_clk_in,    // receiver 1x clock from pin
   output logic [7:0]      rd_data_out,
   output logic            irq_out,
   output logic            rx_irq_req_out,
   output logic            tx_irq_req_out,
   output logic [2:0]      rate_group_out,
   output logic            queue_depth_select_out,
   output logic            rx_enable_out,
   output logic            tx_enable_out,
   output logic [7:0]      mode_one_out,
   output logic [7:0]      mode_two_out
);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   logic [7:0] mode_zero;        // channel_a_mode_zero
   logic [7:0] mode_one;         // channel_a_mode_one
   logic [7:0] mode_two;         // third mode register, stored only
   ufc_ptr_e   mode_reg_pointer; // which mode register is reached
   ufc_code_t  rx_code_eff;      // rx threshold code in force
   ufc_code_t  tx_code_eff;      // tx threshold code in force
   logic [2:0] evt_status;       // sticky event bits
   logic [2:0] evt_enable;       // event enables
   logic       rx_tx_en;         // transmitter enabled
   logic       rx_rx_en;         // receiver enabled
   logic       tick_s1;          // bit clock sync, first stage
   logic       tick_s2;          // bit clock sync, second stage
   logic       tick_s3;          // delayed copy for edge detect
   logic       idle_alarm;       // from the watchdog
   logic       tx_req_d;         // last tx request, for raise detect
   logic       rx_req_d;         // last rx request, for raise detect

   // ---------------------------------------------------------------
   // address decode
   // ---------------------------------------------------------------
   wire hit_mode   = (addr_in == `UFC_ADDR_MODE);
   wire hit_cmd    = (addr_in == `UFC_ADDR_COMMAND);
   wire hit_clear  = (addr_in == `UFC_ADDR_EVT_CLEAR);
   wire hit_enable = (addr_in == `UFC_ADDR_EVT_ENABLE);
   wire mode_acc   = hit_mode && (wr_in || rd_in);
   wire mode_wr    = hit_mode && wr_in;
   wire cmd_wr     = hit_cmd && wr_in;
   wire [3:0] cmd_code =
      wr_data_in[`UFC_CMD_CODE_HI:`UFC_CMD_CODE_LO];
   wire cmd_ptr0   = cmd_wr && (cmd_code == `UFC_CMD_PTR_ZERO);
   wire cmd_ptr1   = cmd_wr && (cmd_code == `UFC_CMD_PTR_ONE);
   wire wr_mode0   = mode_wr && (mode_reg_pointer == UFC_PTR_MODE0);
   wire wr_mode1   = mode_wr && (mode_reg_pointer == UFC_PTR_MODE1);
   wire wr_mode2   = mode_wr && (mode_reg_pointer == UFC_PTR_MODE2);

   // rate code check on the value being written into mode zero
   wire [2:0] wr_rate = wr_data_in[`UFC_M0_RATE_HI:`UFC_M0_RATE_LO];
   wire rate_bad = wr_mode0 && (wr_rate != `UFC_RATE_NORMAL) &&
                   (wr_rate != `UFC_RATE_EXT_ONE) &&
                   (wr_rate != `UFC_RATE_EXT_TWO);

   // ---------------------------------------------------------------
   // pointer sequencing
   // ---------------------------------------------------------------
   ufc_ptr_e next_pointer;
   always_comb begin
      next_pointer = mode_reg_pointer;
      if (cmd_ptr0) begin
         next_pointer = UFC_PTR_MODE0;
      end else if (cmd_ptr1) begin
         next_pointer = UFC_PTR_MODE1;
      end else if (mode_acc) begin
         // each access steps on; the last register is sticky
         case (mode_reg_pointer)
            UFC_PTR_MODE0: next_pointer = UFC_PTR_MODE1;
            UFC_PTR_MODE1: next_pointer = UFC_PTR_MODE2;
            UFC_PTR_MODE2: next_pointer = UFC_PTR_MODE2;
            default:       next_pointer = UFC_PTR_MODE1;
         endcase
      end
   end

   // pointer register, reset points at mode one
   always_ff @(posedge core_clk_in) begin
      if (!resetn_in) mode_reg_pointer <= UFC_PTR_MODE1;
      else            mode_reg_pointer <= next_pointer;
   end

   // mode register storage
   always_ff @(posedge core_clk_in) begin
      if (!resetn_in) begin
         mode_zero <= `UFC_MODE_RESET;
         mode_one  <= `UFC_MODE_RESET;
         mode_two  <= `UFC_MODE_RESET;
      end else begin
         if (wr_mode0) mode_zero <= wr_data_in;
         if (wr_mode1) mode_one  <= wr_data_in;
         if (wr_mode2) mode_two  <= wr_data_in;
      end
   end

   // enable and disable bits of the command register
   always_ff @(posedge core_clk_in) begin
      if (!resetn_in) begin
         rx_tx_en <= 1'b0;
         rx_rx_en <= 1'b0;
      end else if (cmd_wr) begin
         // disable wins if software sets both at once
         if (wr_data_in[`UFC_CMD_TX_OFF])     rx_tx_en <= 1'b0;
         else if (wr_data_in[`UFC_CMD_TX_ON]) rx_tx_en <= 1'b1;
         if (wr_data_in[`UFC_CMD_RX_OFF])     rx_rx_en <= 1'b0;
         else if (wr_data_in[`UFC_CMD_RX_ON]) rx_rx_en <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // thresholds
   // ---------------------------------------------------------------
   wire depth_large = mode_zero[`UFC_M0_DEPTH];
   wire [4:0] depth = depth_large ? `UFC_DEPTH_LARGE : `UFC_DEPTH_SMALL;
   wire ufc_code_t rx_code_new =
      {mode_zero[`UFC_M0_RX_HI], mode_one[`UFC_M1_RX_LO]};
   wire ufc_code_t tx_code_new =
      mode_zero[`UFC_M0_TX_HI:`UFC_M0_TX_LO];

   // a code change only lands when both queues are empty or on an
   // access, so a threshold code never jumps between accesses to a half-full queue
   wire queues_empty = (rx_level_in == 5'h00) && (tx_level_in == 5'h00);
   wire queue_access = rx_queue_read_in || rx_queue_write_in ||
                       tx_queue_read_in || tx_queue_write_in;
   wire code_load    = queues_empty || queue_access;

   always_ff @(posedge core_clk_in) begin
      if (!resetn_in) begin
         rx_code_eff <= 2'h0;
         tx_code_eff <= 2'h0;
      end else if (code_load) begin
         rx_code_eff <= rx_code_new;
         tx_code_eff <= tx_code_new;
      end
   end

   // receiver fill level that raises a request
   wire [4:0] rx_need8 =
      (rx_code_eff == 2'h0) ? `UFC_RX8_T0 :
      (rx_code_eff == 2'h1) ? `UFC_RX8_T1 :
      (rx_code_eff == 2'h2) ? `UFC_RX8_T2 : `UFC_RX8_T3;
   wire [4:0] rx_need16 =
      (rx_code_eff == 2'h0) ? `UFC_RX16_T0 :
      (rx_code_eff == 2'h1) ? `UFC_RX16_T1 :
      (rx_code_eff == 2'h2) ? `UFC_RX16_T2 : `UFC_RX16_T3;
   wire [4:0] rx_need = depth_large ? rx_need16 : rx_need8;

   // transmitter vacancy that raises a request
   wire [4:0] tx_need8 =
      (tx_code_eff == 2'h0) ? `UFC_TX8_T0 :
      (tx_code_eff == 2'h1) ? `UFC_TX8_T1 :
      (tx_code_eff == 2'h2) ? `UFC_TX8_T2 : `UFC_TX8_T3;
   wire [4:0] tx_need16 =
      (tx_code_eff == 2'h0) ? `UFC_TX16_T0 :
      (tx_code_eff == 2'h1) ? `UFC_TX16_T1 :
      (tx_code_eff == 2'h2) ? `UFC_TX16_T2 : `UFC_TX16_T3;
   wire [4:0] tx_need = depth_large ? tx_need16 : tx_need8;

   // a level above the depth means the datapath is confused; clamp
   wire [4:0] tx_vacancy = (tx_level_in >= depth) ? 5'h00 :
                           depth - tx_level_in;

   wire rx_fill_hit  = (rx_level_in >= rx_need);
   // level request, drops the cycle vacancy falls under the need
   wire tx_req_now   = rx_tx_en && (tx_vacancy >= tx_need);
   // the idle alarm joins the ordinary receiver request
   wire rx_req_now   = rx_fill_hit || idle_alarm;

   // ---------------------------------------------------------------
   // receiver bit clock and idle watchdog
   // ---------------------------------------------------------------
   // the pin is asynchronous: two stages before the edge detector
   always_ff @(posedge core_clk_in) begin
      if (!resetn_in) begin
         tick_s1 <= 1'b0;
         tick_s2 <= 1'b0;
         tick_s3 <= 1'b0;
      end else begin
         tick_s1 <= rx_bit_clk_in;
         tick_s2 <= tick_s1;
         tick_s3 <= tick_s2;
      end
   end
   wire bit_tick = tick_s2 && !tick_s3;
   wire wd_on    = mode_zero[`UFC_M0_IDLE_EN];
   // a push also counts as an access, so live traffic never alarms
   wire wd_restart = rx_queue_read_in || rx_queue_write_in;

   ufc_idle_watchdog #(
      .IDLE_BITS (IDLE_BITS)
   ) u_watchdog (
      .core_clk_in (core_clk_in),
      .resetn_in   (resetn_in),
      .tick_in     (bit_tick),
      .enable_in   (wd_on),
      .restart_in  (wd_restart),
      .alarm_out   (idle_alarm)
   );

   // ---------------------------------------------------------------
   // events and interrupt
   // ---------------------------------------------------------------
   wire [2:0] evt_set;
   assign evt_set[`UFC_EVT_TX]   = tx_req_now && !tx_req_d;
   assign evt_set[`UFC_EVT_RX]   = rx_req_now && !rx_req_d;
   assign evt_set[`UFC_EVT_RATE] = rate_bad;
   wire [2:0] evt_clr = (hit_clear && wr_in) ? wr_data_in[2:0] : 3'h0;
   // set beats clear so a same-cycle event is never lost
   wire [2:0] next_evt = (evt_status & ~evt_clr) | evt_set;

   always_ff @(posedge core_clk_in) begin
      if (!resetn_in) begin
         evt_status <= `UFC_EVT_RESET;
         evt_enable <= `UFC_EVT_RESET;
         tx_req_d   <= 1'b0;
         rx_req_d   <= 1'b0;
      end else begin
         evt_status <= next_evt;
         if (hit_enable && wr_in) evt_enable <= wr_data_in[2:0];
         tx_req_d   <= tx_req_now;
         rx_req_d   <= rx_req_now;
      end
   end

   // ---------------------------------------------------------------
   // read mux and outputs
   // ---------------------------------------------------------------
   wire [7:0] mode_rd =
      (mode_reg_pointer == UFC_PTR_MODE0) ? mode_zero :
      (mode_reg_pointer == UFC_PTR_MODE1) ? mode_one  : mode_two;
   // status bits as the channel status register shows them
   wire rx_has_char    = (rx_level_in != 5'h00) || idle_alarm;
   wire rx_queue_full  = (rx_level_in >= depth);
   wire tx_has_space   = rx_tx_en && (tx_level_in < depth);
   wire tx_queue_empty = (tx_level_in == 5'h00);
   wire [7:0] chan_status =
      {4'h0, tx_queue_empty, tx_has_space, rx_queue_full, rx_has_char};
   wire [7:0] int_status  = {6'h00, rx_req_now, tx_req_now};
   wire [7:0] next_rd =
      !rd_in                            ? 8'h00 :
      hit_mode                          ? mode_rd :
      (addr_in == `UFC_ADDR_CHAN_STAT)  ? chan_status :
      (addr_in == `UFC_ADDR_INT_STAT)   ? int_status :
      (addr_in == `UFC_ADDR_EVT_STAT)   ? {5'h00, evt_status} :
      hit_enable                        ? {5'h00, evt_enable} : 8'h00;

   // every output is a flop; read data stand one cycle only
   always_ff @(posedge core_clk_in) begin
      if (!resetn_in) begin
         rd_data_out            <= 8'h00;
         irq_out                <= 1'b0;
         rx_irq_req_out         <= 1'b0;
         tx_irq_req_out         <= 1'b0;
         rate_group_out         <= `UFC_RATE_NORMAL;
         queue_depth_select_out <= 1'b0;
         rx_enable_out          <= 1'b0;
         tx_enable_out          <= 1'b0;
         mode_one_out           <= `UFC_MODE_RESET;
         mode_two_out           <= `UFC_MODE_RESET;
      end else begin
         rd_data_out            <= next_rd;
         irq_out                <= |(next_evt & evt_enable);
         rx_irq_req_out         <= rx_req_now;
         tx_irq_req_out         <= tx_req_now;
         rate_group_out         <=
            mode_zero[`UFC_M0_RATE_HI:`UFC_M0_RATE_LO];
         queue_depth_select_out <= depth_large;
         rx_enable_out          <= rx_rx_en;
         tx_enable_out          <= rx_tx_en;
         mode_one_out           <= mode_one;
         mode_two_out           <= mode_two;
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   sequence s_cmd_b;
      wr_in && hit_cmd && (cmd_code == `UFC_CMD_PTR_ZERO);
   endsequence
   sequence s_mode1_touch;
      mode_acc && (mode_reg_pointer == UFC_PTR_MODE1) &&
      !cmd_ptr0 && !cmd_ptr1;
   endsequence

   a_ptr_cmd_b:
   assert property (@(posedge core_clk_in) disable iff (!resetn_in)
      s_cmd_b |=> (mode_reg_pointer == UFC_PTR_MODE0))
   else $error("command B did not select mode zero");

   a_ptr_step_two:
   assert property (@(posedge core_clk_in) disable iff (!resetn_in)
      s_mode1_touch |=> (mode_reg_pointer == UFC_PTR_MODE2))
   else $error("pointer did not advance after mode one access");

   a_thr_hold_busy:
   assert property (@(posedge core_clk_in) disable iff (!resetn_in)
      (!queues_empty && !queue_access) |=> $stable(rx_code_eff) &&
      $stable(tx_code_eff))
   else $error("threshold changed without empty queues or access");

   a_tx_req_drop:
   assert property (@(posedge core_clk_in) disable iff (!resetn_in)
      (tx_code_eff == 2'h0 && tx_level_in != 5'h00) |=> !tx_irq_req_out)
   else $error("tx request kept with a byte loaded under code zero");

   a_tx_req_empty:
   assert property (@(posedge core_clk_in) disable iff (!resetn_in)
      (rx_tx_en && tx_level_in == 5'h00) |=> tx_irq_req_out)
   else $error("empty enabled transmitter does not request");

   a_rx_full_only:
   assert property (@(posedge core_clk_in) disable iff (!resetn_in)
      (rx_code_eff == 2'h3 && !idle_alarm && !depth_large &&
       rx_level_in == 5'h07) |=> !rx_irq_req_out)
   else $error("rx request below full under code three");

   a_wd_as_rx:
   assert property (@(posedge core_clk_in) disable iff (!resetn_in)
      idle_alarm |=> rx_irq_req_out)
   else $error("idle alarm not shown as receiver request");

   a_rate_flag:
   assert property (@(posedge core_clk_in) disable iff (!resetn_in)
      rate_bad |=> evt_status[`UFC_EVT_RATE])
   else $error("illegal rate code not flagged");
endmodule

// *** verif/ufc_queue_model.sv ***
// behavioural receive and transmit queues facing the mode block
`timescale 1ns/1ps
module ufc_queue_model (
   input  wire logic core_clk_in,
   input  wire logic resetn_in,
   input  wire logic rx_put_in,     // serial side delivers a byte
   input  wire logic rx_take_in,    // host pops a byte
   input  wire logic tx_put_in,     // host loads a byte
   input  wire logic tx_take_in,    // shifter takes a byte
   output logic [4:0] rx_level_out,
   output logic [4:0] tx_level_out,
   output logic      rx_read_out,
   output logic      rx_write_out,
   output logic      tx_read_out,
   output logic      tx_write_out
);
   // a pop of an empty queue is still an access, so it still pulses
   always_ff @(posedge core_clk_in) begin
      if (!resetn_in) begin
         rx_level_out <= 5'h00;
         tx_level_out <= 5'h00;
         {rx_read_out, rx_write_out, tx_read_out, tx_write_out} <= 4'h0;
      end else begin
         {rx_read_out, rx_write_out} <= {rx_take_in, rx_put_in};
         {tx_read_out, tx_write_out} <= {tx_take_in, tx_put_in};
         rx_level_out <= rx_level_out + 5'(rx_put_in)
                         - 5'(rx_take_in && rx_level_out != 5'h00);
         tx_level_out <= tx_level_out + 5'(tx_put_in)
                         - 5'(tx_take_in && tx_level_out != 5'h00);
      end
   end
endmodule

// *** verif/tb_uart_fifo_threshold_config.sv ***
// self-checking bench of the mode configuration block
`timescale 1ns/1ps
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin \
   mismatches++; $display("unexpected %s expected %h seen %h", n, e, a); \
   end end
module tb_uart_fifo_threshold_config;
   logic        core_clk_in = 0, resetn_in = 0, wr_in = 0, rd_in = 0;
   logic        bclk = 0, rxp = 0, rxt = 0, txp = 0, txt = 0;
   logic [3:0]  addr_in = 4'h0;
   logic [7:0]  wdat = 8'h00, rdat;
   logic [31:0] seed = 32'hD61E5F57;        // fixed seed, repeatable run
   wire  [4:0]  rxl, txl;
   wire         rxr, rxw, txr, txw, irq, rxq, txq, dsel, rxe, txe;
   wire  [7:0]  rd_data_out, m1, m2;
   wire  [2:0]  rate;
   int          mismatches = 0, cmp_count = 0, cyc = 0, nt;
   logic [2:0]  g[3] = '{3'h0, 3'h1, 3'h4};   // legal rate groups

   // short watchdog so the idle alarm fits in a few bit times
   ufc_mode_config #(.IDLE_BITS(4)) dut_u (.core_clk_in(core_clk_in),
      .resetn_in(resetn_in), .addr_in(addr_in), .wr_data_in(wdat),
      .wr_in(wr_in), .rd_in(rd_in), .rx_level_in(rxl), .tx_level_in(txl),
      .rx_queue_read_in(rxr), .rx_queue_write_in(rxw),
      .tx_queue_read_in(txr), .tx_queue_write_in(txw), .rx_bit_clk_in(bclk),
      .rd_data_out(rd_data_out), .irq_out(irq), .rx_irq_req_out(rxq),
      .tx_irq_req_out(txq), .rate_group_out(rate),
      .queue_depth_select_out(dsel), .rx_enable_out(rxe), .tx_enable_out(txe),
      .mode_one_out(m1), .mode_two_out(m2));
   ufc_queue_model queue_u (.core_clk_in(core_clk_in), .resetn_in(resetn_in),
      .rx_put_in(rxp), .rx_take_in(rxt), .tx_put_in(txp), .tx_take_in(txt),
      .rx_level_out(rxl), .tx_level_out(txl), .rx_read_out(rxr),
      .rx_write_out(rxw), .tx_read_out(txr), .tx_write_out(txw));

   always #4 core_clk_in = ~core_clk_in;
   // hang guard, far above the roughly 1300 cycles the run needs
   always @(posedge core_clk_in) begin
      cyc++;
      if (cyc == 40000) begin
         mismatches++;
         give_verdict;
      end
   end

   function automatic logic [31:0] lfsr(logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // receive fill needed, indexed by depth select and code
   function automatic logic exp_rx(logic d, logic [1:0] c, int l);
      int t[8] = '{1, 3, 6, 8, 1, 8, 12, 16};
      return l >= t[{d, c}];
   endfunction
   // transmit vacancy needed, indexed the same way
   function automatic logic exp_tx(logic d, logic [1:0] c, int l);
      int t[8] = '{8, 4, 6, 1, 16, 8, 12, 1};
      return (d ? 16 : 8) - l >= t[{d, c}];
   endfunction

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge core_clk_in);
      addr_in <= a;
      wdat <= d;
      wr_in <= 1'b1;
      @(posedge core_clk_in);
      wr_in <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a);
      @(posedge core_clk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge core_clk_in);
      rd_in <= 1'b0;
      #1 rdat = rd_data_out;
   endtask
   // one queue access, then time for level and request to settle
   task automatic acc(input logic a, b, c, d);
      @(posedge core_clk_in);
      {rxp, rxt, txp, txt} <= {a, b, c, d};
      @(posedge core_clk_in);
      {rxp, rxt, txp, txt} <= 4'h0;
      repeat (3) @(posedge core_clk_in);
      #1;
   endtask
   task automatic drain;
      while (rxl != 5'h00 || txl != 5'h00) acc(0, 1, 0, 1);
   endtask
   // pointer to mode zero first, then mode zero and mode one in turn
   task automatic mode(input logic [7:0] a, b);
      wr(4'h2, 8'hB0);
      wr(4'h0, a);
      wr(4'h0, b);
      repeat (2) @(posedge core_clk_in);
      #1;
   endtask
   task automatic bits(input int n);
      repeat (n) begin
         @(posedge core_clk_in);
         bclk <= 1'b1;
         repeat (4) @(posedge core_clk_in);
         bclk <= 1'b0;
         repeat (4) @(posedge core_clk_in);
      end
      repeat (4) @(posedge core_clk_in);
      #1;
   endtask
   task give_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   initial begin
      repeat (8) @(posedge core_clk_in);
      resetn_in <= 1'b1;
      @(posedge core_clk_in);
      #1 `CHK("txq", 1'b0, txq)
      rd(4'h0);
      `CHK("mode1", 8'h00, rdat)
      wr(4'h0, 8'h5A);
      rd(4'hF);
      `CHK("unmapped", 8'h00, rdat)
      `CHK("mode2", 8'h5A, m2)
      wr(4'h2, 8'h10);
      wr(4'h0, 8'h40);
      wr(4'h0, 8'hA5);
      repeat (2) @(posedge core_clk_in);
      #1 `CHK("mode1", 8'h40, m1)
      `CHK("mode2", 8'hA5, m2)
      mode(8'h08, 8'h00);
      `CHK("depth", 1'b1, dsel)
      `CHK("mode1", 8'h00, m1)
      $display("pointer test done");
      wr(4'h2, 8'h05);
      repeat (3) @(posedge core_clk_in);
      #1 `CHK("txq", 1'b1, txq)
      `CHK("txen", 1'b1, txe)
      `CHK("rxen", 1'b1, rxe)
      // every code at every fill level from one byte to full, random transmit loading
      for (int d = 0; d < 2; d++) for (int c = 0; c < 4; c++) begin
         drain();
         mode({1'b0, c[1], c[1:0], d[0], 3'h0}, {1'b0, c[0], 6'h00});
         nt = 0;
         for (int l = 1; l <= (d ? 16 : 8); l++) begin
            seed = lfsr(seed);
            acc(1, 0, seed[0], 0);
            nt += int'(seed[0]);
            `CHK("rxq", exp_rx(d[0], c[1:0], l), rxq)
            `CHK("txq", exp_tx(d[0], c[1:0], nt), txq)
         end
      end
      $display("threshold test done");
      drain();
      mode(8'h00, 8'h00);
      acc(1, 0, 0, 0);
      acc(1, 0, 0, 0);
      wr(4'h2, 8'hB0);
      wr(4'h0, 8'h40);
      repeat (3) @(posedge core_clk_in);
      #1 `CHK("rxq", 1'b1, rxq)
      acc(1, 0, 0, 0);
      `CHK("rxq", 1'b0, rxq)
      drain();
      mode(8'h00, 8'h00);
      bits(5);
      `CHK("rxq", 1'b0, rxq)
      mode(8'h80, 8'h00);
      bits(3);
      `CHK("rxq", 1'b0, rxq)
      bits(1);
      `CHK("rxq", 1'b1, rxq)
      rd(4'h1);
      `CHK("status", 8'h0D, rdat)
      // read data stand one cycle only, then fall back to zero
      @(posedge core_clk_in);
      #1 `CHK("rd_idle", 8'h00, rd_data_out)
      rd(4'h3);
      `CHK("intstat", 8'h03, rdat)
      acc(0, 1, 0, 0);
      `CHK("rxq", 1'b0, rxq)
      $display("watchdog test done");
      // forbidden rate code raises the event, legal ones do not
      wr(4'h5, 8'h07);
      wr(4'h6, 8'h04);
      rd(4'h6);
      `CHK("enable", 8'h04, rdat)
      repeat (2) @(posedge core_clk_in);
      #1 `CHK("irq", 1'b0, irq)
      mode(8'h03, 8'h00);
      `CHK("irq", 1'b1, irq)
      wr(4'h5, 8'h04);
      repeat (2) @(posedge core_clk_in);
      #1 `CHK("irq", 1'b0, irq)
      for (int k = 0; k < 3; k++) begin
         mode({5'h00, g[k]}, 8'h00);
         `CHK("rate", g[k], rate)
         rd(4'h4);
         `CHK("event", 1'b0, rdat[2])
      end
      $display("rate test done");
      // disable beats enable; the transmitter request needs the enable
      wr(4'h2, 8'h0F);
      repeat (2) @(posedge core_clk_in);
      #1 `CHK("txen", 1'b0, txe)
      `CHK("rxen", 1'b0, rxe)
      `CHK("txq", 1'b0, txq)
      wr(4'h2, 8'h04);
      rd(4'h4);
      `CHK("event", 1'b1, rdat[0])
      $display("enable test done");
      give_verdict;
   end
endmodule
